// *** hdl/crg_pkg.sv ***
// Constants shared by the clock, ready and reset generator
package crg_pkg;

  // Register map (byte addresses)
  localparam logic [3:0] CRG_CTRL_OFS    = 4'h0;
  localparam logic [3:0] CRG_STATUS_OFS  = 4'h4;
  localparam logic [3:0] CRG_ID_OFS      = 4'h8;

  // Control fields
  localparam int         CRG_CTRL_HOLD_BIT = 0;
  localparam logic [0:0] CRG_CTRL_RST      = 1'h0;

  // Status fields
  localparam int CRG_ST_READY_BIT  = 0;
  localparam int CRG_ST_RESET_BIT  = 1;
  localparam int CRG_ST_SRC_BIT    = 2;
  localparam int CRG_ST_DEPTH_BIT  = 3;
  localparam int CRG_ST_HOLD_BIT   = 4;
  localparam int CRG_ST_PCLK_BIT   = 5;

  // Arbitrary identification value
  localparam logic [31:0] CRG_ID_VALUE = 32'h0000_C0DE;

  // Divider
  localparam int         CRG_DIV_W     = 2;
  localparam logic [1:0] CRG_CNT_CLEAR = 2'h0;
  localparam logic [1:0] CRG_CNT_HIGH  = 2'h1;
  localparam logic [1:0] CRG_CNT_LAST  = 2'h2;

  // Synchroniser reset levels
  localparam logic [1:0] CRG_SYNC_LOW  = 2'h0;
  localparam logic [1:0] CRG_SYNC_HIGH = 2'h3;

endpackage

// *** hdl/crg_top.sv ***
// Clock, ready and reset generator with Avalon-MM status port
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module crg_top
  import crg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Source pins
  input  wire logic        crystal_pin_a,
  input  wire logic        external_freq_in,
  input  wire logic        source_select_in,
  input  wire logic        clock_sync_in,
  // Reset and ready pins
  input  wire logic        reset_request_n,
  input  wire logic        bus_ready_in_a,
  input  wire logic        bus_ready_in_b,
  input  wire logic        bus_enable_qual_a_n,
  input  wire logic        bus_enable_qual_b_n,
  input  wire logic        ready_sync_depth_sel,
  // Generated outputs
  output logic             osc_out,
  output logic             proc_clk_out,
  output logic             periph_clk_out,
  output logic             proc_reset_out,
  output logic             proc_ready_out,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 10;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  // Depth select idles high, enables idle deasserted, reset request idles asserted
  localparam logic [NPIN-1:0] PIN_RST = 10'h380;

  assign pin_raw = {ready_sync_depth_sel, bus_enable_qual_b_n, bus_enable_qual_a_n,
                    bus_ready_in_b, bus_ready_in_a, reset_request_n, clock_sync_in,
                    source_select_in, external_freq_in, crystal_pin_a};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          pin_s1_r[gi] <= PIN_RST[gi] ? CRG_SYNC_HIGH[0] : CRG_SYNC_LOW[0];
          pin_s2_r[gi] <= PIN_RST[gi] ? CRG_SYNC_HIGH[1] : CRG_SYNC_LOW[1];
        end
        else
        begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  wire xtal_s      = pin_s2_r[0];
  wire efi_s       = pin_s2_r[1];
  wire src_sel_s   = pin_s2_r[2];
  wire clock_sync_in_s     = pin_s2_r[3];
  wire rst_req_n_s = pin_s2_r[4];
  wire rdy_a_s     = pin_s2_r[5];
  wire rdy_b_s     = pin_s2_r[6];
  wire aen_a_n_s   = pin_s2_r[7];
  wire aen_b_n_s   = pin_s2_r[8];
  wire depth_sel_s = pin_s2_r[9];

  // ----------------------------------------------------------------
  // Source edge detection
  // ----------------------------------------------------------------
  logic xtal_d_r;
  logic efi_d_r;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      xtal_d_r <= 1'b0;
      efi_d_r  <= 1'b0;
    end
    else
    begin
      xtal_d_r <= xtal_s;
      efi_d_r  <= efi_s;
    end
  end

  wire xtal_rise = xtal_s & ~xtal_d_r;
  wire efi_rise  = efi_s & ~efi_d_r;
  wire src_tick  = src_sel_s ? efi_rise : xtal_rise;

  // ----------------------------------------------------------------
  // Divide-by-three and peripheral clock
  // ----------------------------------------------------------------
  logic [CRG_DIV_W-1:0] div_cnt_r;
  logic [CRG_DIV_W-1:0] div_cnt_nxt;
  logic                 proc_clk_r;
  logic                 periph_clk_r;
  logic [0:0]           ctrl_hold_r;

  wire div_hold = clock_sync_in_s | ctrl_hold_r[0];
  wire rise_evt = src_tick & ~div_hold & (div_cnt_r == CRG_CNT_CLEAR);
  wire fall_evt = src_tick & ~div_hold & (div_cnt_r == CRG_CNT_HIGH);

  assign div_cnt_nxt = div_hold                     ? CRG_CNT_CLEAR :
                       !src_tick                    ? div_cnt_r     :
                       (div_cnt_r == CRG_CNT_LAST)  ? CRG_CNT_CLEAR :
                       div_cnt_r + CRG_CNT_HIGH;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt_r    <= CRG_CNT_CLEAR;
      proc_clk_r   <= 1'b0;
      periph_clk_r <= 1'b0;
    end
    else
    begin
      div_cnt_r  <= div_cnt_nxt;
      proc_clk_r <= (div_cnt_nxt == CRG_CNT_HIGH);
      if (div_hold)
        periph_clk_r <= 1'b0;
      else if (rise_evt)
        periph_clk_r <= ~periph_clk_r;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator output
  // ----------------------------------------------------------------
  logic osc_r;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      osc_r <= 1'b0;
    else
      osc_r <= xtal_s;
  end

  // ----------------------------------------------------------------
  // Processor reset
  // ----------------------------------------------------------------
  logic proc_reset_r;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      proc_reset_r <= 1'b1;
    else if (fall_evt)
      proc_reset_r <= ~rst_req_n_s;
  end

  // ----------------------------------------------------------------
  // Ready synchronisation
  // ----------------------------------------------------------------
  logic rdy_ff1_r;
  logic rdy_ff2_r;

  wire rdy_qual = (rdy_a_s & ~aen_a_n_s) | (rdy_b_s & ~aen_b_n_s);
  wire two_stage = ~depth_sel_s;
  wire ff2_in = two_stage ? (rdy_qual & rdy_ff1_r) : rdy_qual;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdy_ff1_r <= 1'b0;
      rdy_ff2_r <= 1'b0;
    end
    else
    begin
      if (rise_evt)
        rdy_ff1_r <= rdy_qual;
      if (fall_evt)
        rdy_ff2_r <= ff2_in;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------------------------------
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  wire req      = avs_read | avs_write;
  wire sel_ctrl = (avs_address == CRG_CTRL_OFS);
  wire sel_st   = (avs_address == CRG_STATUS_OFS);
  wire sel_id   = (avs_address == CRG_ID_OFS);
  wire wr_ctrl  = avs_write & ack_r & sel_ctrl & avs_byteenable[0];

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[CRG_ST_READY_BIT] = rdy_ff2_r;
    status_word[CRG_ST_RESET_BIT] = proc_reset_r;
    status_word[CRG_ST_SRC_BIT]   = src_sel_s;
    status_word[CRG_ST_DEPTH_BIT] = depth_sel_s;
    status_word[CRG_ST_HOLD_BIT]  = div_hold;
    status_word[CRG_ST_PCLK_BIT]  = periph_clk_r;
  end

  assign rd_mux = sel_ctrl ? {31'h0000_0000, ctrl_hold_r} :
                  sel_st   ? status_word :
                  sel_id   ? CRG_ID_VALUE : 32'h0000_0000;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ack_r       <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      ctrl_hold_r <= CRG_CTRL_RST;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r)
        rdata_r <= rd_mux;
      if (wr_ctrl)
        ctrl_hold_r <= avs_writedata[CRG_CTRL_HOLD_BIT +: 1];
    end
  end

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  assign osc_out        = osc_r;
  assign proc_clk_out   = proc_clk_r;
  assign periph_clk_out = periph_clk_r;
  assign proc_reset_out = proc_reset_r;
  assign proc_ready_out = rdy_ff2_r;

endmodule

`default_nettype wire

// *** testbench/crg_monitor.sv ***
// Assertion checker for the clock, ready and reset generator
`timescale 1ns/1ps
`default_nettype none
module crg_monitor (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic crystal_pin_a,
  input wire logic clock_sync_in,
  input wire logic bus_ready_in_a,
  input wire logic bus_ready_in_b,
  input wire logic bus_enable_qual_a_n,
  input wire logic bus_enable_qual_b_n,
  input wire logic osc_out,
  input wire logic proc_clk_out,
  input wire logic periph_clk_out,
  input wire logic proc_reset_out,
  input wire logic proc_ready_out
);
  logic       qual;
  logic       off;
  logic [5:0] idle_r;
  assign qual = (bus_ready_in_a & ~bus_enable_qual_a_n)
              | (bus_ready_in_b & ~bus_enable_qual_b_n);
  assign off  = ~reset_n_in | clock_sync_in;
  // ----
  // Cycles without a qualified ready, saturating
  // ----
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      idle_r <= 6'h00;
    else
      idle_r <= qual ? 6'h00 : idle_r + {5'h00, ~&idle_r};
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  AST_CLK_HIGH: assert property (disable iff (off) $rose(proc_clk_out) |-> proc_clk_out[*6])
    else $error("clock high phase short");
  AST_CLK_LOW: assert property (disable iff (off) $fell(proc_clk_out) |-> !proc_clk_out[*8])
    else $error("clock low phase short");
  AST_PCLK_PHASE: assert property ($rose(periph_clk_out) |-> ##[0:2] proc_clk_out)
    else $error("periph clock out of phase");
  AST_SYNC_HOLD: assert property (clock_sync_in[*6] |-> !proc_clk_out && !periph_clk_out)
    else $error("clocks run while held");
  AST_OSC_FOLLOW: assert property ($changed(osc_out) |-> osc_out == $past(crystal_pin_a, 3))
    else $error("osc not following crystal");
  AST_RESET_EDGE: assert property ($changed(proc_reset_out) |-> ##[0:2] $fell(proc_clk_out))
    else $error("reset moved off falling edge");
  AST_READY_EDGE: assert property ($changed(proc_ready_out) |-> ##[0:2] $fell(proc_clk_out))
    else $error("ready moved off falling edge");
  AST_READY_QUAL: assert property (idle_r > 6'h28 |-> !proc_ready_out)
    else $error("ready without qualified input");
  cover property ($rose(proc_ready_out));
  cover property ($fell(proc_reset_out));
  cover property (clock_sync_in[*8]);
endmodule
bind crg_top crg_monitor u_mon (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .crystal_pin_a(crystal_pin_a), .clock_sync_in(clock_sync_in),
  .bus_ready_in_a(bus_ready_in_a), .bus_ready_in_b(bus_ready_in_b),
  .bus_enable_qual_a_n(bus_enable_qual_a_n), .bus_enable_qual_b_n(bus_enable_qual_b_n),
  .osc_out(osc_out), .proc_clk_out(proc_clk_out), .periph_clk_out(periph_clk_out),
  .proc_reset_out(proc_reset_out), .proc_ready_out(proc_ready_out));
`default_nettype wire

// *** testbench/crg_partner.sv ***
// Far-side model: crystal, external source and clock sync driver
`timescale 1ns/1ps
`default_nettype none
module crg_partner (
  input  wire logic ref_clk_in,
  input  wire logic sync_req_in,
  output var  logic crystal_out,
  output var  logic ext_freq_out,
  output var  logic clock_sync_out
);
  logic [1:0] xtal_r = 2'h0;
  logic [1:0] ext_r  = 2'h0;
  initial
  begin
    crystal_out    = 1'b0;
    ext_freq_out   = 1'b0;
    clock_sync_out = 1'b0;
  end
  // ----
  // Crystal period 8 cycles, external period 6
  // ----
  always @(posedge ref_clk_in)
  begin
    xtal_r <= xtal_r + 2'h1;
    ext_r  <= (ext_r == 2'h2) ? 2'h0 : ext_r + 2'h1;
    if (xtal_r == 2'h3)
      crystal_out <= ~crystal_out;
    if (ext_r == 2'h2)
      ext_freq_out <= ~ext_freq_out;
    if (ext_r == 2'h2 && !ext_freq_out)
      clock_sync_out <= sync_req_in;
  end
endmodule
`default_nettype wire

// *** testbench/crg_top_bench.sv ***
// Self-checking bench for the clock, ready and reset generator
`timescale 1ns/1ps
`default_nettype none
module crg_top_bench
  import crg_pkg::*;
;
  logic        ref_clk_in = 1'b0, reset_n_in = 1'b0, source_select_in = 1'b0;
  logic        sync_req = 1'b0;
  logic        reset_request_n = 1'b0, ready_sync_depth_sel = 1'b1;
  logic        bus_ready_in_a = 1'b0, bus_ready_in_b = 1'b0;
  logic        bus_enable_qual_a_n = 1'b1, bus_enable_qual_b_n = 1'b1;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        osc_out, proc_clk_out, periph_clk_out, proc_reset_out, proc_ready_out;
  wire         crystal_pin_a, external_freq_in, clock_sync_in;
  wire  [2:0]  mon = {osc_out, periph_clk_out, proc_clk_out};
  int          errors = 0, checks = 0, n;
  logic [5:0]  rows [6] = '{6'h27, 6'h36, 6'h1B, 6'h0C, 6'h29, 6'h00};
  always #12.5 ref_clk_in = ~ref_clk_in;
  crg_top dut_u (.*);
  crg_partner far_u (.ref_clk_in(ref_clk_in), .sync_req_in(sync_req),
    .crystal_out(crystal_pin_a), .ext_freq_out(external_freq_in), .clock_sync_out(clock_sync_in));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge ref_clk_in); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic falls(input int k);
    repeat (k) @(negedge proc_clk_out);
    #1;
  endtask
  task automatic meas(input int s, input logic [7:0] hi_e, input logic [7:0] lo_e);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'hFF;
    lo = 8'h00;
    wait (mon[s] === 1'b0);
    wait (mon[s] === 1'b1);
    do @(posedge ref_clk_in) hi++; while (mon[s]);
    do @(posedge ref_clk_in) lo++; while (!mon[s]);
    chk("high_time", {24'h0, hi_e}, {24'h0, hi});
    chk("low_time", {24'h0, lo_e}, {24'h0, lo});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk("reset_out", 32'h1, {31'h0, proc_reset_out});
    @(posedge ref_clk_in);
    reset_request_n <= 1'b1;
    falls(3);
    chk("reset_out", 32'h0, {31'h0, proc_reset_out});
    foreach (rows[i])
    begin
      @(posedge ref_clk_in);
      {bus_ready_in_a, bus_enable_qual_a_n, bus_ready_in_b, bus_enable_qual_b_n,
       ready_sync_depth_sel} <= rows[i][5:1];
      falls(3);
      chk("ready", {31'h0, rows[i][0]}, {31'h0, proc_ready_out});
    end
    // Single master: both qualifiers held low
    @(posedge ref_clk_in);
    {bus_ready_in_a, bus_enable_qual_a_n, bus_ready_in_b, bus_enable_qual_b_n} <= 4'h8;
    falls(2);
    chk("ready_both_en", 32'h1, {31'h0, proc_ready_out});
    @(posedge ref_clk_in);
    bus_ready_in_a <= 1'b0;
    falls(2);
    chk("ready_both_en", 32'h0, {31'h0, proc_ready_out});
    @(posedge ref_clk_in);
    reset_request_n <= 1'b0;
    falls(2);
    chk("reset_out", 32'h1, {31'h0, proc_reset_out});
    meas(0, 8'h08, 8'h10);
    meas(1, 8'h18, 8'h18);
    meas(2, 8'h04, 8'h04);
    // Switch to external source just after a fall, before any clock sync
    falls(1);
    @(posedge ref_clk_in);
    source_select_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    sync_req <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    chk("held_clocks", 32'h0, {30'h0, periph_clk_out, proc_clk_out});
    bus(1'b1, CRG_CTRL_OFS, 32'h1);
    bus(1'b0, CRG_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    bus(1'b0, CRG_STATUS_OFS, 32'h0);
    chk("held_flag", 32'h1, {31'h0, rd[CRG_ST_HOLD_BIT]});
    bus(1'b0, CRG_ID_OFS, 32'h0);
    chk("ident", CRG_ID_VALUE, rd);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, CRG_CTRL_OFS, 32'h0);
    repeat (20) @(posedge ref_clk_in);
    sync_req <= 1'b0;
    wait (clock_sync_in === 1'b0);
    n = 0;
    while (proc_clk_out !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk("restart", 32'h1, {31'h0, n < 14});
    meas(0, 8'h06, 8'h0C);
    meas(2, 8'h04, 8'h04);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
